// File: pkg/brc_map.svh
/*
 * Register offsets, field positions, reset values and frame figures of the
 * burst resolution control register group.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef BRC_MAP_SVH
`define BRC_MAP_SVH

`define BRC_ADDR_W 7
`define BRC_OFS_PATTERN 7'h36
`define BRC_OFS_BURST 7'h37
`define BRC_OFS_COARSE_B3 7'h39
`define BRC_OFS_COARSE_B2 7'h3a
`define BRC_OFS_COARSE_B1 7'h3b
`define BRC_OFS_COARSE_B0 7'h3c
`define BRC_OFS_FINE_B3 7'h3d
`define BRC_OFS_FINE_B2 7'h3e
`define BRC_OFS_FINE_B1 7'h3f
`define BRC_OFS_FINE_B0 7'h40

`define BRC_POLY_HI 7
`define BRC_POLY_LO 6
`define BRC_BIT_UPPER_EN 7
`define BRC_BIT_LOWER_EN 6
`define BRC_BIT_LOAD_EN 5
`define BRC_BIT_SWAP 4
`define BRC_BIT_INT_TRIG 3
`define BRC_BIT_RATIO_BAD 1

`define BRC_RESET_BYTE 8'h00
`define BRC_RATIO_MIN 30'h0000003
`define BRC_FRAME_BITS 5'h10
`define BRC_HEAD_BITS 5'h08

`endif

// File: pkg/brc_pkg.sv
/*
 * Types shared by the burst resolution control register group.
 * Assumes brc_map.svh is on the include path.
 */
`include "brc_map.svh"

package brc_pkg;

	typedef logic [27:0] brc_count_t;

	// Per pair configuration as stored by the register port.
	typedef struct packed {
		logic [1:0] pattern_poly_sel;
		logic upper_lsb_res_flag_en;
		logic lower_lsb_res_flag_en;
		logic count_load_en;
		logic trigger_pin_swap;
		logic internal_trigger_en;
		brc_count_t fine_sample_count;
	} brc_pair_cfg_t;

	// Per pair status returned by the burst sequencer.
	typedef struct packed {
		logic ratio_bad;
		brc_count_t coarse_sample_count;
	} brc_pair_stat_t;

	typedef enum logic [2:0] {
		BRC_IDLE = 3'h1,
		BRC_HIRES = 3'h2,
		BRC_LORES = 3'h4
	} brc_state_t;

	// Alarm when the coarse count is below three times the fine count.
	function automatic logic brc_ratio_bad(input brc_count_t coarse,
		input brc_count_t fine);
		logic [29:0] f3;
		f3 = `BRC_RATIO_MIN * {2'h0, fine};
		return {2'h0, coarse} < f3;
	endfunction

endpackage

// File: test/brc_host_model.sv
/*
 * Host model of the serial register port: sends 16-bit frames MSB first and
 * reports the read byte of each read frame with a one-cycle strobe.
 * Assumes clk_i is the 40 MHz system clock and the bench sets the page.
 */
`timescale 1ns/1ps
`default_nettype none

module brc_host_model (
	input wire logic clk_i,
	input wire logic sdout_i,
	output logic sclk_o,
	output logic sen_n_o,
	output logic sdata_o,
	output logic rd_valid_o,
	output logic [7:0] rd_data_o
);
	initial begin
		sclk_o = 1'b0;
		sen_n_o = 1'b1;
		sdata_o = 1'b0;
		rd_valid_o = 1'b0;
		rd_data_o = 8'h00;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Phases of six cycles leave room for the two-flop synchroniser.
	// Callers pick the page and keep unused bits zero first.
	task automatic xfer(input logic rd, input logic [6:0] a,
		input logic [7:0] d);
		logic [15:0] f;
		f = {rd, a, d};
		step(4);
		sen_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdata_o = f[i];
			step(6);
			sclk_o = 1'b1;
			if (i < 8) begin
				rd_data_o[i] = sdout_i;
			end
			step(6);
			sclk_o = 1'b0;
		end
		sen_n_o = 1'b1;
		// A released line must not look like a held copy of the last bit.
		sdata_o = ~sdata_o;
		if (rd) begin
			rd_valid_o = 1'b1;
			step(1);
			rd_valid_o = 1'b0;
		end
	endtask
endmodule

`default_nettype wire

// File: test/brc_regs_tb.sv
/*
 * Self-checking bench of the burst resolution control registers.
 * Assumes the package and the host model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module brc_regs_tb;
	import brc_pkg::*;
	logic clk_i, rst_i, pin1, pin2, sclk, sen_n, sdata, sdout, rv, h;
	logic hab, hcd, auto_on;
	logic [1:0] page, pab, pcd, lab, lcd, l;
	logic [1:0] hl[2];
	logic [7:0] rd;
	logic [31:0] e, b;
	logic [31:0] rq[$];
	logic [31:0] bq[2][$];
	logic [6:0] ra[12] = '{7'h36, 7'h37, 7'h38, 7'h39, 7'h3a, 7'h3b,
		7'h3c, 7'h3d, 7'h3e, 7'h3f, 7'h40, 7'h50};
	int miscompares, checks_done, seed, nauto;
	int hw[2];
	brc_count_t cab, ccd, fine, old;

	brc_host_model i_host(.clk_i(clk_i), .sdout_i(sdout), .sclk_o(sclk),
		.sen_n_o(sen_n), .sdata_o(sdata), .rd_valid_o(rv), .rd_data_o(rd));
	brc_regs i_dut(
		.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .sen_n_i(sen_n),
		.sdata_i(sdata), .sdout_o(sdout), .lane_pair_page_i(page),
		.trigger_pin_pair1_i(pin1), .trigger_pin_pair2_i(pin2),
		.coarse_ab_i(cab), .coarse_cd_i(ccd), .poly_ab_o(pab),
		.poly_cd_o(pcd), .lsb_ab_o(lab), .lsb_cd_o(lcd),
		.high_res_ab_o(hab), .high_res_cd_o(hcd));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_host.xfer(1'b0, a, d);
	endtask

	task automatic rd_exp(input logic [6:0] a, input logic [7:0] x);
		rq.push_back({17'h0, a, x});
		i_host.xfer(1'b1, a, 8'h00);
	endtask

	function automatic logic [7:0] byte_of(input brc_count_t c, input int k);
		logic [31:0] w;
		w = {4'h0, c};
		return w[31 - 8 * k -: 8];
	endfunction

	task automatic wr_cnt(input brc_count_t c);
		for (int k = 0; k < 4; k++) wr(7'h3d + 7'(k), byte_of(c, k));
	endtask

	task automatic rd_cnt(input logic [6:0] a, input brc_count_t c);
		for (int k = 0; k < 4; k++) rd_exp(a + 7'(k), byte_of(c, k));
	endtask

	task automatic pulse(input logic two);
		{pin2, pin1} = two ? 2'h2 : 2'h1;
		tick(3);
		{pin2, pin1} = 2'h0;
		tick(50);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Results are matched against the notes in the order they were made.
	always @(posedge clk_i) begin
		if (rv === 1'b1) begin
			e = rq.size() ? rq.pop_front() : 32'hffff_ffff;
			chk($sformatf("reg %h", e[14:8]), e[7:0], {24'h0, rd});
		end
		for (int p = 0; p < 2; p++) begin
			h = p ? hcd : hab;
			l = p ? lcd : lab;
			if (h === 1'b1) begin
				if (hw[p] == 0) hl[p] = l;
				hw[p]++;
			end else begin
				if (l !== 2'h0) chk("lsb idle", 32'h0, {30'h0, l});
				if (hw[p] != 0) begin
					b = {hl[p], 30'(hw[p])};
					if (p == 0 && auto_on) begin
						nauto++;
						chk("auto burst", 32'd10, b);
					end else begin
						e = bq[p].size() ? bq[p].pop_front() : 32'h0;
						chk($sformatf("burst %0d", p), e, b);
					end
					hw[p] = 0;
				end
			end
		end
	end

	initial begin
		repeat (60000) @(posedge clk_i);
		miscompares++;
		results();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 62;
		{miscompares, checks_done, nauto, hw[0], hw[1]} = '0;
		{rst_i, pin1, pin2, auto_on, page, cab, ccd} = '0;
		rst_i = 1'b1;
		tick(3);
		rst_i = 1'b0;
		tick(6);
		foreach (ra[i]) rd_exp(ra[i], 8'h00);
		$display("test reset done");
		page = 2'h1;
		for (int v = 0; v < 4; v++) begin
			wr(7'h36, {v[1:0], 6'h00});
			rd_exp(7'h36, {v[1:0], 6'h00});
			chk("poly ab", {30'h0, v[1:0]}, {30'h0, pab});
			chk("poly cd", 32'h0, {30'h0, pcd});
		end
		$display("test poly done");
		page = 2'h3;
		fine = brc_count_t'($random(seed));
		wr_cnt(fine);
		rd_cnt(7'h3d, fine);
		wr(7'h3a, 8'hff);
		rd_exp(7'h3a, 8'h00);
		cab = brc_count_t'($random(seed));
		ccd = brc_count_t'($random(seed));
		wr(7'h37, 8'h20);
		rd_cnt(7'h39, cab);
		page = 2'h2;
		rd_cnt(7'h39, ccd);
		page = 2'h3;
		wr(7'h37, 8'h00);
		old = cab;
		cab = ~cab;
		rd_cnt(7'h39, old);
		$display("test counts done");
		wr_cnt(28'd10);
		cab = 28'd29;
		ccd = 28'd30;
		wr(7'h37, 8'h20);
		rd_exp(7'h37, 8'h22);
		cab = 28'd30;
		rd_exp(7'h37, 8'h20);
		$display("test ratio done");
		for (int k = 0; k < 4; k++) begin
			wr(7'h37, {k[1:0], 6'h20});
			bq[0].push_back({k[1:0], 30'd10});
			pulse(1'b0);
		end
		$display("test flags done");
		page = 2'h1;
		wr(7'h37, 8'h30);
		page = 2'h2;
		wr(7'h37, 8'he0);
		pulse(1'b0);
		bq[0].push_back({2'h0, 30'd10});
		bq[1].push_back({2'h3, 30'd10});
		pulse(1'b1);
		$display("test swap done");
		page = 2'h1;
		auto_on = 1'b1;
		wr(7'h28 + 7'h0f, 8'h28);
		pulse(1'b0);
		tick(100);
		wr(7'h37, 8'h20);
		tick(60);
		auto_on = 1'b0;
		chk("auto count", 32'h1, {31'h0, nauto >= 3});
		bq[0].push_back({2'h0, 30'd10});
		pulse(1'b0);
		chk("queues left", 32'h0, rq.size() + bq[0].size() + bq[1].size());
		$display("test auto done");
		results();
	end
endmodule

`default_nettype wire

// File: verilog/brc_burst_seq.sv
/*
 * Burst sequencer of one lane pair: holds the working counts, alternates
 * fine and coarse periods and drives the resolution flag on the two LSBs.
 * Assumes a trigger already synchronised and selected by the register port.
 */
`timescale 1ns/1ps
`default_nettype none

module brc_burst_seq
	import brc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire brc_pkg::brc_pair_cfg_t cfg_i,
	input wire brc_pkg::brc_count_t coarse_i,
	input wire logic trig_i,
	output logic high_res_o,
	output logic [1:0] lsb_o,
	output brc_pkg::brc_pair_stat_t stat_o
);
	import brc_pkg::*;

	brc_state_t state, next_state;
	brc_count_t fine_w, next_fine_w, coarse_w, next_coarse_w;
	brc_count_t cnt, next_cnt;
	logic trig_q, next_trig_q, start, next_high_res;
	logic [1:0] next_lsb;
	brc_pair_stat_t next_stat;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_trig_q = trig_i;
		next_fine_w = fine_w;
		next_coarse_w = coarse_w;
		if (cfg_i.count_load_en) begin
			next_fine_w = cfg_i.fine_sample_count;
			next_coarse_w = coarse_i;
		end
		// Auto mode restarts at once; pin edges are ignored there.
		start = cfg_i.internal_trigger_en ? 1'b1 : (trig_i & ~trig_q);
		next_state = state;
		next_cnt = cnt;
		unique case (state)
			BRC_IDLE: begin
				if (start) begin
					next_state = BRC_HIRES;
					next_cnt = 28'h0000001;
				end
			end
			BRC_HIRES: begin
				next_cnt = cnt + 28'h0000001;
				if (cnt >= fine_w) begin
					next_state = BRC_LORES;
					next_cnt = 28'h0000001;
				end
			end
			BRC_LORES: begin
				next_cnt = cnt + 28'h0000001;
				if (cnt >= coarse_w) begin
					next_state = cfg_i.internal_trigger_en ? BRC_HIRES : BRC_IDLE;
					next_cnt = 28'h0000001;
				end
			end
		endcase
		next_high_res = (next_state == BRC_HIRES);
		next_lsb[1] = next_high_res & cfg_i.upper_lsb_res_flag_en;
		next_lsb[0] = next_high_res & cfg_i.lower_lsb_res_flag_en;
		next_stat.coarse_sample_count = coarse_w;
		next_stat.ratio_bad = brc_ratio_bad(coarse_w, fine_w);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= BRC_IDLE;
			fine_w <= 28'h0000000;
			coarse_w <= 28'h0000000;
			cnt <= 28'h0000000;
			trig_q <= 1'b0;
			high_res_o <= 1'b0;
			lsb_o <= 2'h0;
			stat_o <= '0;
		end else begin
			state <= next_state;
			fine_w <= next_fine_w;
			coarse_w <= next_coarse_w;
			cnt <= next_cnt;
			trig_q <= next_trig_q;
			high_res_o <= next_high_res;
			lsb_o <= next_lsb;
			stat_o <= next_stat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_upper_lsb_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!cfg_i.upper_lsb_res_flag_en |=> !lsb_o[1])
		else $error("upper lsb set while its enable was clear");
	chk_lower_lsb_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 lsb_o[0] == ($past(cfg_i.lower_lsb_res_flag_en) && high_res_o))
		else $error("lower lsb does not follow the resolution flag");
	chk_counts_held: assert property (@(posedge clk_i) disable iff (rst_i)
		!cfg_i.count_load_en |=> fine_w == $past(fine_w) && coarse_w == $past(coarse_w))
		else $error("working counts changed without load enable");
	chk_counts_loaded: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_i.count_load_en |=> fine_w == $past(cfg_i.fine_sample_count))
		else $error("working fine count not loaded");
	chk_pin_start: assert property (@(posedge clk_i) disable iff (rst_i)
		!cfg_i.internal_trigger_en && state == BRC_IDLE && !(trig_i && !trig_q)
		|=> state == BRC_IDLE)
		else $error("burst started without a pin trigger");
	chk_auto_start: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_i.internal_trigger_en && state == BRC_IDLE |=> state == BRC_HIRES)
		else $error("internal trigger did not start a burst");
	chk_ratio_alarm: assert property (@(posedge clk_i) disable iff (rst_i)
		##2 stat_o.ratio_bad == ({2'h0, $past(coarse_i, 2)} < 30'h3 * {2'h0, $past(cfg_i.fine_sample_count, 2)})
		|| !$past(cfg_i.count_load_en, 2) || !$past(cfg_i.count_load_en))
		else $error("ratio alarm does not match the loaded counts");
	chk_fine_period: assert property (@(posedge clk_i) disable iff (rst_i)
		state == BRC_HIRES && cnt >= fine_w |=> state == BRC_LORES)
		else $error("fine period did not end on its count");
	cov_auto_burst: cover property (@(posedge clk_i) disable iff (rst_i)
		state == BRC_LORES && cfg_i.internal_trigger_en ##1 state == BRC_HIRES);
	cov_pin_burst: cover property (@(posedge clk_i) disable iff (rst_i)
		state == BRC_IDLE && !cfg_i.internal_trigger_en ##1 state == BRC_HIRES);
	cov_ratio_bad: cover property (@(posedge clk_i) disable iff (rst_i)
		stat_o.ratio_bad);

endmodule

`default_nettype wire

// File: verilog/brc_regs.sv
/*
 * Burst resolution control registers of the two lane pair pages, reached
 * over the serial register port, with one burst sequencer per pair.
 * Assumes the serial clock is far slower than clk_i and that lane_pair_page_i
 * comes from page logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

`include "brc_map.svh"

module brc_regs
	import brc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic sen_n_i,
	input wire logic sdata_i,
	output logic sdout_o,
	input wire logic [1:0] lane_pair_page_i,
	input wire logic trigger_pin_pair1_i,
	input wire logic trigger_pin_pair2_i,
	input wire brc_pkg::brc_count_t coarse_ab_i,
	input wire brc_pkg::brc_count_t coarse_cd_i,
	output logic [1:0] poly_ab_o,
	output logic [1:0] poly_cd_o,
	output logic [1:0] lsb_ab_o,
	output logic [1:0] lsb_cd_o,
	output logic high_res_ab_o,
	output logic high_res_cd_o
);
	import brc_pkg::*;

	logic [2:0] sclk_s, next_sclk_s;
	logic [1:0] sen_s, next_sen_s, dat_s, next_dat_s;
	logic [1:0] trg1_s, next_trg1_s, trg2_s, next_trg2_s;
	logic [4:0] bits, next_bits;
	logic [15:0] in_sr, next_in_sr;
	logic [7:0] out_sr, next_out_sr;
	logic next_sdout, rise, fall, frame;
	brc_pair_cfg_t cfg [2];
	brc_pair_cfg_t next_cfg [2];
	brc_pair_stat_t stat [2];
	logic [1:0] trig_sel;
	logic [1:0] lsb_q [2];
	logic hr_q [2];
	brc_count_t coarse_in [2];
	logic [7:0] rdata;
	logic [6:0] addr;

	function automatic logic [7:0] read_byte(input brc_pair_cfg_t c,
		input brc_pair_stat_t s, input logic [6:0] a);
		logic [7:0] r;
		r = `BRC_RESET_BYTE;
		unique case (a)
			`BRC_OFS_PATTERN: r = {c.pattern_poly_sel, 6'h00};
			`BRC_OFS_BURST: r = {c.upper_lsb_res_flag_en, c.lower_lsb_res_flag_en,
				c.count_load_en, c.trigger_pin_swap, c.internal_trigger_en,
				1'b0, s.ratio_bad, 1'b0};
			`BRC_OFS_COARSE_B3: r = {4'h0, s.coarse_sample_count[27:24]};
			`BRC_OFS_COARSE_B2: r = s.coarse_sample_count[23:16];
			`BRC_OFS_COARSE_B1: r = s.coarse_sample_count[15:8];
			`BRC_OFS_COARSE_B0: r = s.coarse_sample_count[7:0];
			`BRC_OFS_FINE_B3: r = {4'h0, c.fine_sample_count[27:24]};
			`BRC_OFS_FINE_B2: r = c.fine_sample_count[23:16];
			`BRC_OFS_FINE_B1: r = c.fine_sample_count[15:8];
			`BRC_OFS_FINE_B0: r = c.fine_sample_count[7:0];
			default: r = `BRC_RESET_BYTE;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pins are resynchronised; edges are judged on the second and third
	// stages only, never on the first.
	assign rise = sclk_s[1] & ~sclk_s[2];
	assign fall = ~sclk_s[1] & sclk_s[2];
	assign frame = ~sen_s[1];
	assign addr = in_sr[6:0];
	// A read answers from the AB page whenever its page bit is set, else from CD.
	assign rdata = lane_pair_page_i[0] ? read_byte(cfg[0], stat[0], addr)
		: read_byte(cfg[1], stat[1], addr);

	always_comb begin
		next_sclk_s = {sclk_s[1:0], sclk_i};
		next_sen_s = {sen_s[0], sen_n_i};
		next_dat_s = {dat_s[0], sdata_i};
		next_trg1_s = {trg1_s[0], trigger_pin_pair1_i};
		next_trg2_s = {trg2_s[0], trigger_pin_pair2_i};
		next_bits = bits;
		next_in_sr = in_sr;
		next_out_sr = out_sr;
		next_cfg = cfg;
		if (!frame) begin
			next_bits = 5'h00;
		end else if (rise && bits < `BRC_FRAME_BITS) begin
			next_bits = bits + 5'h01;
			next_in_sr = {in_sr[14:0], dat_s[1]};
			if (bits == `BRC_FRAME_BITS - 5'h01 && !in_sr[14]) begin
				for (int p = 0; p < 2; p++) begin
					// Each page is written only when selected.
					if (lane_pair_page_i[p]) begin
						unique case (in_sr[13:7])
							`BRC_OFS_PATTERN: begin
								next_cfg[p].pattern_poly_sel = in_sr[6:5];
							end
							`BRC_OFS_BURST: begin
								next_cfg[p].upper_lsb_res_flag_en = in_sr[6];
								next_cfg[p].lower_lsb_res_flag_en = in_sr[5];
								next_cfg[p].count_load_en = in_sr[4];
								next_cfg[p].trigger_pin_swap = in_sr[3];
								next_cfg[p].internal_trigger_en = in_sr[2];
							end
							`BRC_OFS_FINE_B3: begin
								next_cfg[p].fine_sample_count[27:24] = {in_sr[2:0], dat_s[1]};
							end
							`BRC_OFS_FINE_B2: begin
								next_cfg[p].fine_sample_count[23:16] = {in_sr[6:0], dat_s[1]};
							end
							`BRC_OFS_FINE_B1: begin
								next_cfg[p].fine_sample_count[15:8] = {in_sr[6:0], dat_s[1]};
							end
							`BRC_OFS_FINE_B0: begin
								next_cfg[p].fine_sample_count[7:0] = {in_sr[6:0], dat_s[1]};
							end
							default: begin
							end
						endcase
					end
				end
			end
		end else if (fall && bits == `BRC_HEAD_BITS && in_sr[7]) begin
			next_out_sr = rdata;
		end else if (fall && bits > `BRC_HEAD_BITS) begin
			next_out_sr = {out_sr[6:0], 1'b0};
		end
		next_sdout = frame & out_sr[7];
		// Swap makes each pair listen to the other pair's pin.
		trig_sel[0] = cfg[0].trigger_pin_swap ? trg2_s[1] : trg1_s[1];
		trig_sel[1] = cfg[1].trigger_pin_swap ? trg1_s[1] : trg2_s[1];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_s <= 3'h0;
			sen_s <= 2'h3;
			dat_s <= 2'h0;
			trg1_s <= 2'h0;
			trg2_s <= 2'h0;
			bits <= 5'h00;
			in_sr <= 16'h0000;
			out_sr <= 8'h00;
			sdout_o <= 1'b0;
			cfg[0] <= '0;
			cfg[1] <= '0;
		end else begin
			sclk_s <= next_sclk_s;
			sen_s <= next_sen_s;
			dat_s <= next_dat_s;
			trg1_s <= next_trg1_s;
			trg2_s <= next_trg2_s;
			bits <= next_bits;
			in_sr <= next_in_sr;
			out_sr <= next_out_sr;
			sdout_o <= next_sdout;
			cfg <= next_cfg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign coarse_in[0] = coarse_ab_i;
	assign coarse_in[1] = coarse_cd_i;

	for (genvar p = 0; p < 2; p++) begin : g_pair
		brc_burst_seq u_seq (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.cfg_i(cfg[p]),
			.coarse_i(coarse_in[p]),
			.trig_i(trig_sel[p]),
			.high_res_o(hr_q[p]),
			.lsb_o(lsb_q[p]),
			.stat_o(stat[p])
		);
	end

	assign poly_ab_o = cfg[0].pattern_poly_sel;
	assign poly_cd_o = cfg[1].pattern_poly_sel;
	assign lsb_ab_o = lsb_q[0];
	assign lsb_cd_o = lsb_q[1];
	assign high_res_ab_o = hr_q[0];
	assign high_res_cd_o = hr_q[1];

	////////////////////////////////////////////////////////////////////////
	chk_swap_select: assert property (@(posedge clk_i) disable iff (rst_i)
		trig_sel[0] == (cfg[0].trigger_pin_swap ? $past(trigger_pin_pair2_i, 2)
		: $past(trigger_pin_pair1_i, 2))
		&& trig_sel[1] == (cfg[1].trigger_pin_swap
		? $past(trigger_pin_pair1_i, 2) : $past(trigger_pin_pair2_i, 2)))
		else $error("trigger pin routing wrong");
	chk_reset_zero: assert property (@(posedge clk_i)
		$past(rst_i) |-> cfg[0] == '0 && cfg[1] == '0 && lsb_ab_o == 2'h0)
		else $error("registers not zero after reset");
	chk_poly_write: assert property (@(posedge clk_i) disable iff (rst_i)
		!(frame && rise) |=> poly_ab_o == $past(poly_ab_o))
		else $error("polynomial select changed outside a write");
	chk_coarse_read: assert property (@(posedge clk_i) disable iff (rst_i)
		fall && frame && bits == 5'h08 && in_sr[7] && in_sr[6:0] == 7'h3c
		&& lane_pair_page_i[0] |=> out_sr == $past(stat[0].coarse_sample_count[7:0]))
		else $error("coarse count low byte not returned");
	cov_write_burst: cover property (@(posedge clk_i) disable iff (rst_i)
		cfg[0].count_load_en && cfg[0].internal_trigger_en);
	cov_swap_used: cover property (@(posedge clk_i) disable iff (rst_i)
		cfg[1].trigger_pin_swap && trig_sel[1]);

endmodule

`default_nettype wire
